// file: core/flpm_regs.sv
/*
 * register bank: rx/tx fifo level info and power management control,
 * reached as an apb slave with zero wait states.
 * assumes fifo and power-state events are synchronous to pclk,
 * except the transceiver clock indication, which is synchronised here.
 */
`timescale 1ns/1ps
module flpm_regs
    import flpm_pkg::*;
#(
    parameter int XCVR_RST_CYC = FLPM_XCVR_RST_CYC,
    parameter int WDOG_CYC = FLPM_WDOG_CYC,
    parameter logic [15:0] TX_FIFO_BYTES = FLPM_TX_FREE_RST
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire flpm_apb_req_t apb_req,
    output flpm_apb_rsp_t apb_rsp,
    // fifo level events
    input wire logic rx_frame_valid,
    input wire logic [15:0] rx_frame_len,
    input wire logic rx_read_valid,
    input wire logic [15:0] rx_read_bytes,
    input wire logic tx_write_valid,
    input wire logic [15:0] tx_write_bytes,
    input wire logic tx_sent_valid,
    input wire logic [15:0] tx_sent_bytes,
    // power state events
    input wire logic host_suspend,
    input wire logic resume_done,
    input wire logic resume_remote,
    input wire logic deconfigure,
    input wire logic configure,
    input wire logic hw_config_done,
    input wire logic lite_reset,
    input wire logic xcvr_clk_present,
    input wire flpm_wake_evt_t wake_evt,
    // outputs to the device
    output logic [1:0] sleep_state_sel,
    output logic transceiver_reset_out,
    output logic usb_nak_all,
    output logic clear_mac_wake_flags,
    output logic wake_request
);

    // ****************************************
    // state
    // ****************************************
    logic [15:0] rx_fifo_used_bytes_reg;
    logic [15:0] tx_fifo_free_bytes_reg;
    logic resume_clears_wake_status_reg;
    logic resume_clears_wake_enables_reg;
    logic ready_reg;
    logic [1:0] sleep_sel_reg;
    logic transceiver_reset_request_reg;
    logic lan_wake_enable_reg;
    logic energy_wake_enable_reg;
    logic [1:0] wake_cause_status_reg;
    logic lan_armed_reg;
    logic energy_armed_reg;
    logic last_wake_mac_reg;
    flpm_pwr_state_t pwr_state_reg;
    logic [31:0] rst_cnt_reg;
    logic [31:0] wdog_cnt_reg;
    logic waiting_ready_reg;
    logic clk_sync1_reg;
    logic clk_sync2_reg;
    flpm_apb_rsp_t rsp_reg;
    logic clear_mac_reg;
    logic wake_req_reg;

    logic wr_en;
    logic rd_en;
    logic [31:0] pm_word;
    logic [15:0] rx_add;
    logic [1:0] wake_new;
    logic resume_mac;

    // ****************************************
    // bus decode
    // ****************************************
    // zero wait state: pready rises in the access phase itself
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;

    always_comb begin
        pm_word = 32'h0000_0000;
        pm_word[FLPM_RES_CLR_STS_BIT] = resume_clears_wake_status_reg;
        pm_word[FLPM_RES_CLR_EN_BIT] = resume_clears_wake_enables_reg;
        pm_word[FLPM_READY_BIT] = ready_reg;
        pm_word[FLPM_SLEEP_LSB +: 2] = sleep_sel_reg;
        pm_word[FLPM_XCVR_RST_BIT] = transceiver_reset_request_reg;
        pm_word[FLPM_LAN_WAKE_BIT] = lan_wake_enable_reg;
        pm_word[FLPM_ENERGY_WAKE_BIT] = energy_wake_enable_reg;
        pm_word[1:0] = wake_cause_status_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.pready <= apb_req.psel && !apb_req.penable;
            rsp_reg.pslverr <= 1'b0;
            rsp_reg.prdata <= 32'h0000_0000;
            if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
                case (apb_req.paddr)
                    FLPM_RX_INFO_OFS: rsp_reg.prdata <= {16'h0000, rx_fifo_used_bytes_reg};
                    FLPM_TX_INFO_OFS: rsp_reg.prdata <= {16'h0000, tx_fifo_free_bytes_reg};
                    FLPM_PM_CTL_OFS: rsp_reg.prdata <= pm_word;
                    default: rsp_reg.pslverr <= 1'b1;
                endcase
            end else if (apb_req.psel && !apb_req.penable) begin
                rsp_reg.pslverr <= !(apb_req.paddr == FLPM_PM_CTL_OFS
                    || apb_req.paddr == FLPM_RX_INFO_OFS
                    || apb_req.paddr == FLPM_TX_INFO_OFS);
            end
        end
    end
    assign apb_rsp = rsp_reg;

    // ****************************************
    // fifo levels
    // ****************************************
    assign rx_add = rx_frame_valid ? ((rx_frame_len + 16'h0003) & 16'hfffc) : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_fifo_used_bytes_reg <= FLPM_RX_USED_RST;
        end else begin
            rx_fifo_used_bytes_reg <= rx_fifo_used_bytes_reg + rx_add
                - (rx_read_valid ? rx_read_bytes : 16'h0000);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_fifo_free_bytes_reg <= TX_FIFO_BYTES;
        end else begin
            tx_fifo_free_bytes_reg <= tx_fifo_free_bytes_reg
                - (tx_write_valid ? tx_write_bytes : 16'h0000)
                + (tx_sent_valid ? tx_sent_bytes : 16'h0000);
        end
    end

    // ****************************************
    // power state and suspend selection
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_state_reg <= FLPM_NORMAL_UNCONF;
        end else if (deconfigure) begin
            pwr_state_reg <= FLPM_NORMAL_UNCONF;
        end else begin
            case (pwr_state_reg)
                FLPM_NORMAL_UNCONF: if (configure) pwr_state_reg <= FLPM_NORMAL_CONF;
                FLPM_NORMAL_CONF: if (host_suspend) pwr_state_reg <= FLPM_SUSPENDED;
                FLPM_SUSPENDED: if (resume_done) pwr_state_reg <= FLPM_NORMAL_CONF;
                default: pwr_state_reg <= FLPM_NORMAL_UNCONF;
            endcase
        end
    end

    // software keeps unconfigured selection at state 2 and never pairs it
    // with a wake cause clear, so writes are stored as given
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_sel_reg <= FLPM_SLEEP_RST;
        end else if (deconfigure) begin
            sleep_sel_reg <= FLPM_SLEEP_RST;
        end else if (wr_en && apb_req.paddr == FLPM_PM_CTL_OFS) begin
            sleep_sel_reg <= apb_req.pwdata[FLPM_SLEEP_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_clears_wake_status_reg <= 1'b0;
            resume_clears_wake_enables_reg <= FLPM_RES_CLR_EN_RST;
        end else if (wr_en && apb_req.paddr == FLPM_PM_CTL_OFS) begin
            resume_clears_wake_status_reg <= apb_req.pwdata[FLPM_RES_CLR_STS_BIT];
            resume_clears_wake_enables_reg <= apb_req.pwdata[FLPM_RES_CLR_EN_BIT];
        end
    end

    // ****************************************
    // wake enables and wake cause
    // ****************************************
    assign resume_mac = resume_done && pwr_state_reg == FLPM_SUSPENDED
        && last_wake_mac_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lan_wake_enable_reg <= 1'b0;
            energy_wake_enable_reg <= 1'b0;
        end else if (resume_done && resume_remote && pwr_state_reg == FLPM_SUSPENDED
                     && resume_clears_wake_enables_reg) begin
            lan_wake_enable_reg <= 1'b0;
            energy_wake_enable_reg <= 1'b0;
        end else if (wr_en && apb_req.paddr == FLPM_PM_CTL_OFS) begin
            lan_wake_enable_reg <= apb_req.pwdata[FLPM_LAN_WAKE_BIT];
            energy_wake_enable_reg <= apb_req.pwdata[FLPM_ENERGY_WAKE_BIT];
        end
    end

    // enables are latched on entry so later writes cannot arm a sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lan_armed_reg <= 1'b0;
            energy_armed_reg <= 1'b0;
        end else if (pwr_state_reg == FLPM_NORMAL_CONF && host_suspend) begin
            lan_armed_reg <= lan_wake_enable_reg;
            energy_armed_reg <= energy_wake_enable_reg;
        end else if (pwr_state_reg != FLPM_SUSPENDED) begin
            lan_armed_reg <= 1'b0;
            energy_armed_reg <= 1'b0;
        end
    end

    always_comb begin
        wake_new = 2'h0;
        if (pwr_state_reg == FLPM_SUSPENDED) begin
            if (energy_armed_reg && wake_evt.energy_event) begin
                wake_new[0] = 1'b1;
            end
            if (lan_armed_reg && (wake_evt.lan_event || wake_evt.wake_frame
                                  || wake_evt.magic_packet)) begin
                wake_new[1] = 1'b1;
            end
        end
    end

    // set wins over the clear and over the resume clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cause_status_reg <= FLPM_WAKE_NONE;
        end else begin
            logic [1:0] st;
            st = wake_cause_status_reg;
            if (wr_en && apb_req.paddr == FLPM_PM_CTL_OFS && |apb_req.pwdata[1:0]) begin
                st = FLPM_WAKE_NONE;
            end
            if (resume_mac && resume_clears_wake_status_reg) begin
                st[1] = 1'b0;
            end
            if (wake_new != 2'h0) begin
                if (st != FLPM_WAKE_NONE && st != wake_new) begin
                    st = FLPM_WAKE_MULTI;
                end else if (wake_new == 2'h3) begin
                    st = FLPM_WAKE_MULTI;
                end else begin
                    st = wake_new;
                end
            end
            wake_cause_status_reg <= st;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_wake_mac_reg <= 1'b0;
        end else if (pwr_state_reg == FLPM_NORMAL_CONF && host_suspend) begin
            last_wake_mac_reg <= 1'b0;
        end else if (lan_armed_reg && (wake_evt.wake_frame || wake_evt.magic_packet)) begin
            last_wake_mac_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_mac_reg <= 1'b0;
            wake_req_reg <= 1'b0;
        end else begin
            clear_mac_reg <= resume_mac && resume_clears_wake_status_reg;
            wake_req_reg <= wake_new != 2'h0;
        end
    end

    // ****************************************
    // transceiver reset
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transceiver_reset_request_reg <= 1'b0;
            rst_cnt_reg <= 32'h0000_0000;
        end else if (transceiver_reset_request_reg) begin
            // writes here are ignored until the hold time ends
            if (rst_cnt_reg >= 32'(XCVR_RST_CYC - 1)) begin
                transceiver_reset_request_reg <= 1'b0;
                rst_cnt_reg <= 32'h0000_0000;
            end else begin
                rst_cnt_reg <= rst_cnt_reg + 32'h0000_0001;
            end
        end else if (wr_en && apb_req.paddr == FLPM_PM_CTL_OFS
                     && apb_req.pwdata[FLPM_XCVR_RST_BIT]) begin
            transceiver_reset_request_reg <= 1'b1;
        end
    end

    // ****************************************
    // ready flag
    // ****************************************
    // the clock indication comes from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync1_reg <= 1'b0;
            clk_sync2_reg <= 1'b0;
        end else begin
            clk_sync1_reg <= xcvr_clk_present;
            clk_sync2_reg <= clk_sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            waiting_ready_reg <= 1'b1;
            wdog_cnt_reg <= 32'h0000_0000;
        end else if (lite_reset || (configure && pwr_state_reg == FLPM_NORMAL_UNCONF)) begin
            ready_reg <= 1'b0;
            waiting_ready_reg <= 1'b1;
            wdog_cnt_reg <= 32'h0000_0000;
        end else if (waiting_ready_reg && hw_config_done && pwr_state_reg != FLPM_SUSPENDED) begin
            if (clk_sync2_reg) begin
                ready_reg <= 1'b1;
                waiting_ready_reg <= 1'b0;
            end else if (wdog_cnt_reg >= 32'(WDOG_CYC - 1)) begin
                ready_reg <= 1'b1;
                waiting_ready_reg <= 1'b0;
            end else begin
                wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign sleep_state_sel = sleep_sel_reg;
    assign transceiver_reset_out = transceiver_reset_request_reg;
    assign usb_nak_all = transceiver_reset_request_reg;
    assign clear_mac_wake_flags = clear_mac_reg;
    assign wake_request = wake_req_reg;

endmodule : flpm_regs

// file: core/flpm_pkg.sv
/*
 * package for the fifo level and power management register bank:
 * offsets, field positions, reset values, timing counts, carrier structs.
 * assumes a 25 MHz apb clock and 32-bit aligned registers.
 */
package flpm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] FLPM_RX_INFO_OFS = 12'h018;
    localparam logic [11:0] FLPM_TX_INFO_OFS = 12'h01c;
    localparam logic [11:0] FLPM_PM_CTL_OFS = 12'h020;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FLPM_RES_CLR_STS_BIT = 9;
    localparam int FLPM_RES_CLR_EN_BIT = 8;
    localparam int FLPM_READY_BIT = 7;
    localparam int FLPM_SLEEP_LSB = 5;
    localparam int FLPM_XCVR_RST_BIT = 4;
    localparam int FLPM_LAN_WAKE_BIT = 3;
    localparam int FLPM_ENERGY_WAKE_BIT = 2;

    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [15:0] FLPM_RX_USED_RST = 16'h0000;
    localparam logic [15:0] FLPM_TX_FREE_RST = 16'h2000;
    localparam logic [1:0] FLPM_SLEEP_RST = 2'h2;
    localparam logic FLPM_RES_CLR_EN_RST = 1'h1;
    localparam logic [1:0] FLPM_WAKE_NONE = 2'h0;
    localparam logic [1:0] FLPM_WAKE_ENERGY = 2'h1;
    localparam logic [1:0] FLPM_WAKE_LAN = 2'h2;
    localparam logic [1:0] FLPM_WAKE_MULTI = 2'h3;

    // ****************************************
    // timing
    // ****************************************
    localparam int FLPM_CLK_HZ = 25000000;
    localparam int FLPM_XCVR_RST_US = 2000;
    localparam int FLPM_XCVR_RST_CYC = (FLPM_CLK_HZ / 1000000) * FLPM_XCVR_RST_US;
    localparam int FLPM_WDOG_CYC = 8192;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } flpm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } flpm_apb_rsp_t;

    typedef struct packed {
        logic wake_frame;
        logic magic_packet;
        logic lan_event;
        logic energy_event;
    } flpm_wake_evt_t;

    typedef enum logic [1:0] {
        FLPM_NORMAL_UNCONF,
        FLPM_NORMAL_CONF,
        FLPM_SUSPENDED
    } flpm_pwr_state_t;

endpackage : flpm_pkg

// file: tb/flpm_regs_monitor.sv
/*
 * checker for the fifo level and power management register bank.
 * assumes it is bound to flpm_regs and that everything runs on pclk.
 */
`timescale 1ns/1ps
module flpm_regs_monitor
    import flpm_pkg::*;
#(
    parameter int XCVR_RST_CYC = FLPM_XCVR_RST_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus
    input wire flpm_apb_req_t apb_req,
    input wire flpm_apb_rsp_t apb_rsp,
    // events
    input wire logic resume_done,
    input wire logic deconfigure,
    input wire flpm_wake_evt_t wake_evt,
    // outputs
    input wire logic [1:0] sleep_state_sel,
    input wire logic transceiver_reset_out,
    input wire logic usb_nak_all,
    input wire logic clear_mac_wake_flags,
    input wire logic wake_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    int rst_cnt_reg;
    logic rd_pm;
    logic wr_pm;
    logic mapped;
    assign mapped = apb_req.paddr inside {FLPM_RX_INFO_OFS, FLPM_TX_INFO_OFS, FLPM_PM_CTL_OFS};
    assign rd_pm = apb_rsp.pready && apb_req.paddr == FLPM_PM_CTL_OFS && !apb_req.pwrite;
    assign wr_pm = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == FLPM_PM_CTL_OFS;
    // counts high cycles of the transceiver reset; a restart by a late write shows as too long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_reg <= 0;
        end else begin
            rst_cnt_reg <= transceiver_reset_out ? rst_cnt_reg + 1 : 0;
        end
    end
    chk_zero_wait: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("pready missing in access phase");
    chk_unmapped_err: assert property (
        apb_rsp.pready && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_rsvd_zero: assert property (rd_pm |-> apb_rsp.prdata[31:10] == 22'h0)
        else $error("reserved bits not zero");
    chk_sel_visible: assert property (rd_pm |-> apb_rsp.prdata[6:5] == sleep_state_sel)
        else $error("suspend selection differs from output");
    chk_xrst_start: assert property (
        wr_pm && apb_req.pwdata[4] && !transceiver_reset_out |=> transceiver_reset_out)
        else $error("transceiver reset not started");
    chk_xrst_hold: assert property (
        $fell(transceiver_reset_out) |-> rst_cnt_reg == XCVR_RST_CYC)
        else $error("transceiver reset length wrong");
    chk_nak_match: assert property (usb_nak_all == transceiver_reset_out)
        else $error("nak differs from transceiver reset");
    chk_deconf_sel: assert property (deconfigure |=> sleep_state_sel == FLPM_SLEEP_RST)
        else $error("deconfigure did not restore selection");
    chk_clear_cause: assert property (clear_mac_wake_flags |-> $past(resume_done))
        else $error("mac flag clear without resume");
    chk_wake_cause: assert property (wake_request |-> $past(wake_evt) != 4'h0)
        else $error("wake request without event");
endmodule : flpm_regs_monitor

// file: tb/flpm_regs_test.sv
/*
 * self-checking bench for flpm_regs: apb register access and event pulses.
 * assumes short transceiver reset and watchdog counts set by parameter.
 */
`timescale 1ns/1ps
module flpm_regs_test
    import flpm_pkg::*;
;
    localparam int XC = 20;
    localparam int WD = 16;
    localparam int P_SUS = 0, P_RES = 1, P_DEC = 2, P_CFG = 3, P_LITE = 4, P_WF = 5, P_MP = 6;
    localparam int P_LAN = 7, P_ED = 8, P_RXF = 9, P_RXR = 10, P_TXW = 11, P_TXS = 12;
    logic pclk, presetn, resume_remote, hw_config_done, xcvr_clk_present, last_err;
    logic [12:0] pv;
    logic [15:0] rx_frame_len, rx_read_bytes, tx_write_bytes, tx_sent_bytes, rx_exp;
    logic [1:0] sleep_state_sel;
    logic transceiver_reset_out, usb_nak_all, clear_mac_wake_flags, wake_request;
    flpm_apb_req_t req;
    flpm_apb_rsp_t rsp;
    int mismatches, n_compared, n_clr, n_wake;
    logic [31:0] r;
    logic [15:0] lens [3] = '{16'h0005, 16'h0008, 16'h0001};

    flpm_regs #(.XCVR_RST_CYC(XC), .WDOG_CYC(WD)) i_dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .rx_frame_valid(pv[P_RXF]), .rx_frame_len(rx_frame_len),
        .rx_read_valid(pv[P_RXR]), .rx_read_bytes(rx_read_bytes), .tx_write_valid(pv[P_TXW]),
        .tx_write_bytes(tx_write_bytes), .tx_sent_valid(pv[P_TXS]),
        .tx_sent_bytes(tx_sent_bytes), .host_suspend(pv[P_SUS]), .resume_done(pv[P_RES]),
        .resume_remote(resume_remote), .deconfigure(pv[P_DEC]), .configure(pv[P_CFG]),
        .hw_config_done(hw_config_done), .lite_reset(pv[P_LITE]),
        .xcvr_clk_present(xcvr_clk_present),
        .wake_evt({pv[P_WF], pv[P_MP], pv[P_LAN], pv[P_ED]}),
        .sleep_state_sel(sleep_state_sel), .transceiver_reset_out(transceiver_reset_out),
        .usb_nak_all(usb_nak_all), .clear_mac_wake_flags(clear_mac_wake_flags),
        .wake_request(wake_request));

    // ****************************************
    // clock, watchdog, helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        give_verdict();
    end
    always @(posedge pclk) if (clear_mac_wake_flags === 1'b1) n_clr++;
    always @(posedge pclk) if (wake_request === 1'b1) n_wake++;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // no wait limit here: only the watchdog ends a hung transfer
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        last_err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(a, 1'b0, 32'h0);
        check(what, r, exp);
    endtask : rd

    // ready is masked here; it has its own checks
    task automatic rd_pm(input logic [31:0] exp);
        apb(FLPM_PM_CTL_OFS, 1'b0, 32'h0);
        check("pm control", r & 32'hffff_ff7f, exp);
    endtask : rd_pm

    task automatic pulse(input int i);
        @(posedge pclk);
        pv[i] <= 1'b1;
        @(posedge pclk);
        pv[i] <= 1'b0;
    endtask : pulse

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {presetn, resume_remote, hw_config_done, pv, rx_exp} = '0;
        {rx_frame_len, rx_read_bytes, tx_write_bytes, tx_sent_bytes} = '0;
        xcvr_clk_present = 1'b1;
        req = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(FLPM_PM_CTL_OFS, 1'b0, 32'h0);
        check("pm reset", r, 32'h0000_0140);
        rd(FLPM_RX_INFO_OFS, 32'h0, "rx reset");
        rd(FLPM_TX_INFO_OFS, 32'h2000, "tx reset");
        rd(12'h024, 32'h0, "unmapped");
        check("slverr", last_err, 1'b1);
        apb(FLPM_RX_INFO_OFS, 1'b1, 32'hffff_ffff);
        apb(FLPM_TX_INFO_OFS, 1'b1, 32'hffff_ffff);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'hffff_fd40);
        rd(FLPM_RX_INFO_OFS, 32'h0, "rx ro");
        rd(FLPM_TX_INFO_OFS, 32'h2000, "tx ro");
        rd_pm(32'h0000_0140);
        for (int i = 0; i < 3; i++) begin
            rx_frame_len <= lens[i];
            rx_exp = rx_exp + ((lens[i] + 16'h3) & 16'hfffc);
            pulse(P_RXF);
            rd(FLPM_RX_INFO_OFS, {16'h0, rx_exp}, "rx used");
        end
        rx_read_bytes <= 16'h0004;
        pulse(P_RXR);
        rd(FLPM_RX_INFO_OFS, {16'h0, rx_exp - 16'h4}, "rx read");
        tx_write_bytes <= 16'h0010;
        pulse(P_TXW);
        rd(FLPM_TX_INFO_OFS, 32'h1ff0, "tx free");
        tx_sent_bytes <= 16'h0010;
        pulse(P_TXS);
        rd(FLPM_TX_INFO_OFS, 32'h2000, "tx sent");
        hw_config_done <= 1'b1;
        pulse(P_CFG);
        repeat (6) @(posedge pclk);
        apb(FLPM_PM_CTL_OFS, 1'b0, 32'h0);
        check("ready", r[7], 1'b1);
        xcvr_clk_present <= 1'b0;
        repeat (4) @(posedge pclk);
        pulse(P_LITE);
        apb(FLPM_PM_CTL_OFS, 1'b0, 32'h0);
        check("ready early", r[7], 1'b0);
        repeat (WD + 4) @(posedge pclk);
        apb(FLPM_PM_CTL_OFS, 1'b0, 32'h0);
        check("ready late", r[7], 1'b1);
        xcvr_clk_present <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(FLPM_PM_CTL_OFS, 1'b1, 32'h100 | (i << 5));
            rd_pm(32'h100 | (i << 5));
            check("sel out", sleep_state_sel, i);
        end
        pulse(P_DEC);
        rd_pm(32'h0000_0140);
        pulse(P_CFG);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_0150);
        rd_pm(32'h0000_0150);
        check("nak", usb_nak_all, 1'b1);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_0150);
        // read lands two edges after the first hold ends; a restart would still show bit 4
        repeat (XC - 6) @(posedge pclk);
        rd_pm(32'h0000_0140);
        check("xcvr reset", transceiver_reset_out, 1'b0);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_014c);
        pulse(P_SUS);
        pulse(P_LAN);
        rd_pm(32'h0000_014e);
        pulse(P_ED);
        rd_pm(32'h0000_014f);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_014d);
        rd_pm(32'h0000_014c);
        pulse(P_ED);
        rd_pm(32'h0000_014d);
        resume_remote <= 1'b1;
        pulse(P_RES);
        rd_pm(32'h0000_0141);
        check("no flag clear", n_clr, 0);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_034e);
        rd_pm(32'h0000_034c);
        pulse(P_SUS);
        pulse(P_MP);
        rd_pm(32'h0000_034e);
        resume_remote <= 1'b0;
        pulse(P_RES);
        rd_pm(32'h0000_034c);
        check("flag clear", n_clr, 1);
        pulse(P_SUS);
        pulse(P_ED);
        rd_pm(32'h0000_034d);
        pulse(P_RES);
        rd_pm(32'h0000_034d);
        check("flag clear once", n_clr, 1);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_0343);
        pulse(P_SUS);
        pulse(P_WF);
        pulse(P_LAN);
        pulse(P_ED);
        rd_pm(32'h0000_0340);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_034c);
        pulse(P_ED);
        rd_pm(32'h0000_034c);
        apb(FLPM_PM_CTL_OFS, 1'b1, 32'h0000_004c);
        resume_remote <= 1'b1;
        pulse(P_RES);
        rd_pm(32'h0000_004c);
        check("wake requests", n_wake, 5);
        give_verdict();
    end
endmodule : flpm_regs_test

bind flpm_regs flpm_regs_monitor #(.XCVR_RST_CYC(XCVR_RST_CYC)) i_mon (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .resume_done(resume_done),
    .deconfigure(deconfigure), .wake_evt(wake_evt), .sleep_state_sel(sleep_state_sel),
    .transceiver_reset_out(transceiver_reset_out), .usb_nak_all(usb_nak_all),
    .clear_mac_wake_flags(clear_mac_wake_flags), .wake_request(wake_request));
